// ---- hdl/sec_pkg.sv ----
package sec_pkg;

   // ==========================================================
   // instruction codes, bit 3 masked off before compare
   localparam logic [7:0] OP_MASK        = 8'hF7;
   localparam logic [7:0] OPC_SET_LATCH  = 8'h06;
   localparam logic [7:0] OPC_CLR_LATCH  = 8'h04;
   localparam logic [7:0] OPC_STAT_READ  = 8'h05;
   localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
   localparam logic [7:0] OPC_ARR_READ   = 8'h03;
   localparam logic [7:0] OPC_ARR_WRITE  = 8'h02;

   typedef enum logic [2:0] {
      CMD_NONE       = 3'b000,
      CMD_SET_LATCH  = 3'b001,
      CMD_CLR_LATCH  = 3'b010,
      CMD_STAT_READ  = 3'b011,
      CMD_STAT_WRITE = 3'b100,
      CMD_ARR_READ   = 3'b101,
      CMD_ARR_WRITE  = 3'b110,
      CMD_BAD        = 3'b111
   } sec_cmd_t;

   // ==========================================================
   // bit positions within a frame (index of the rising edge)
   localparam logic [5:0] BIT_OP_LAST    = 6'h07;
   localparam logic [5:0] BIT_ADDR_FIRST = 6'h08;
   localparam logic [5:0] BIT_ADDR_LAST  = 6'h17;
   localparam logic [5:0] BIT_SW_LAST    = 6'h0F;
   localparam logic [5:0] BIT_AW_LAST    = 6'h1F;
   localparam logic [5:0] BIT_CNT_MAX    = 6'h3F;

   // ==========================================================
   // status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       hw_protect_arm;
      logic [2:0] spare;
      logic [1:0] protect_level;
      logic       writeLatch;
      logic       busy;
   } sec_stat_t;

   localparam logic [7:0] STAT_BUSY_VIEW   = 8'hFF;
   localparam logic [1:0] PROT_LEVEL_SHIP  = 2'b00;
   localparam logic       ARM_SHIP         = 1'b0;
   localparam logic [1:0] PROT_NONE        = 2'b00;
   localparam logic [1:0] PROT_QUARTER     = 2'b01;
   localparam logic [1:0] PROT_HALF        = 2'b10;
   localparam logic [9:0] PROT_QUARTER_LOW = 10'h300;
   localparam logic [9:0] PROT_HALF_LOW    = 10'h200;

   // ==========================================================
   // request passed from the link side to the core side
   typedef struct packed {
      sec_cmd_t    cmd;
      logic [15:0] addr;
      logic [7:0]  data;
   } sec_req_t;

   // pins and link levels seen by the core clock
   typedef struct packed {
      logic csN;
      logic holdN;
      logic wpN;
      logic readMode;
      logic reqTog;
   } sec_pins_t;

   // ==========================================================
   // self-timed write cycle
   localparam int unsigned WC_TIME_US = 5000;
   localparam int unsigned CLK_MHZ    = 125;
   localparam int unsigned WC_CYCLES  = WC_TIME_US * CLK_MHZ;

   function automatic sec_cmd_t sec_decode(input logic [7:0] op);
      sec_cmd_t c;
      c = CMD_BAD;
      if (op[7:4] == 4'h0)
      begin
         unique case (op & OP_MASK)
            OPC_SET_LATCH:  c = CMD_SET_LATCH;
            OPC_CLR_LATCH:  c = CMD_CLR_LATCH;
            OPC_STAT_READ:  c = CMD_STAT_READ;
            OPC_STAT_WRITE: c = CMD_STAT_WRITE;
            OPC_ARR_READ:   c = CMD_ARR_READ;
            OPC_ARR_WRITE:  c = CMD_ARR_WRITE;
            default:        c = CMD_BAD;
         endcase
      end
      return c;
   endfunction

endpackage

// ---- hdl/sec_sync.sv ----
`timescale 1ns/100ps

// ==========================================================
// two-stage level synchroniser, one per bit
module sec_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clock, // destination clock
   input  wire logic [W-1:0] d,     // foreign levels
   output logic      [W-1:0] q      // synchronised levels
);

   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clock)
   begin
      meta <= d;
      q    <= meta;
   end

endmodule // sec_sync

// ---- hdl/sec_wc_timer.sv ----
`timescale 1ns/100ps

// ==========================================================
// self-timed write cycle counter
module sec_wc_timer
   import sec_pkg::*;
#(
   parameter int unsigned CYCLES = WC_CYCLES
)
(
   input  wire logic clock, // core clock
   input  wire logic rst,   // synchronous reset
   input  wire logic start, // one-cycle start pulse
   output logic      done   // one-cycle end pulse
);

   localparam int W = $clog2(CYCLES + 1);

   logic         running;
   logic [W-1:0] count;

   // count the cycle; a start while running is ignored
   always_ff @(posedge clock)
   begin
      done <= 1'b0;
      if (rst)
      begin
         running <= 1'b0;
         count   <= '0;
      end
      else if (!running && start)
      begin
         running <= 1'b1;
         count   <= '0;
      end
      else if (running)
      begin
         if (count == W'(CYCLES - 1))
         begin
            running <= 1'b0;
            done    <= 1'b1;
         end
         else
            count <= count + 1'b1;
      end
   end

endmodule // sec_wc_timer

// ---- hdl/sec_eeprom_front.sv ----
`timescale 1ns/100ps

module sec_eeprom_front
   import sec_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WC_CYCLES
)
(
   input  wire logic       clock,           // core clock
   input  wire logic       rst,             // sync reset, high
   input  wire logic       sck,             // serial link clock
   input  wire logic       csN,             // chip select, low
   input  wire logic       si,              // serial data in
   input  wire logic       holdN,           // pause, low
   input  wire logic       wpN,             // write protect, low
   output logic            so,              // serial data out
   output logic            soEnN,           // so enable, low
   output logic            busy,            // write cycle running
   output logic            arrayWriteGo,    // array write start
   output logic [9:0]      arrayWriteAddr,  // array write address
   output logic [7:0]      arrayWriteData   // array write byte
);

   // ==========================================================
   // link side declarations
   logic [5:0]  bitCnt;
   logic [7:0]  inShift;
   logic [7:0]  nextByte;
   sec_cmd_t    opCmd;
   sec_req_t    pend;
   logic        reqTog;
   logic        readMode;
   logic [2:0]  outCnt;
   logic [7:0]  outByte;
   logic [7:0]  statSync;
   logic [7:0]  statPrev;
   logic [7:0]  statStable;
   logic        linkRst;

   // ==========================================================
   // core side declarations
   sec_pins_t   pinS;
   logic        csPrev;
   logic        lastTog;
   logic        togNew;
   logic        csRise;
   sec_req_t    cap;
   logic        capValid;
   logic        exec;
   sec_req_t    req;
   logic        hwProt;
   logic        arrProt;
   logic        startWc;
   logic        wcDone;
   sec_cmd_t    wcKind;
   logic [7:0]  wcData;
   logic        writeLatch;
   logic [1:0]  protLevel;
   logic        hwArm;
   sec_stat_t   statView;

   // ==========================================================
   // link side: instruction shifter

   assign nextByte = {inShift[6:0], si};
   assign opCmd    = sec_decode(nextByte);

   // frame position; select high clears it without any clock
   always_ff @(posedge sck or posedge csN)
   begin
      if (csN)
      begin
         bitCnt  <= '0;
         inShift <= '0;
      end
      else if (holdN)
      begin
         if (bitCnt != BIT_CNT_MAX)
            bitCnt <= bitCnt + 1'b1;
         inShift <= nextByte;
      end
   end

   // requests outlive the frame so the core can fetch them late
   always_ff @(posedge sck or posedge linkRst)
   begin
      if (linkRst)
      begin
         pend   <= '0;
         reqTog <= 1'b0;
      end
      else if (!csN && holdN)
      begin
         if (bitCnt == BIT_OP_LAST)
         begin
            pend.cmd  <= opCmd;
            pend.addr <= '0;
            pend.data <= '0;
            if (opCmd == CMD_SET_LATCH || opCmd == CMD_CLR_LATCH)
               reqTog <= ~reqTog;
         end
         if (bitCnt >= BIT_ADDR_FIRST && bitCnt <= BIT_ADDR_LAST)
            pend.addr <= {pend.addr[14:0], si};
         if (bitCnt == BIT_SW_LAST && pend.cmd == CMD_STAT_WRITE)
         begin
            pend.data <= nextByte;
            reqTog    <= ~reqTog;
         end
         if (bitCnt == BIT_AW_LAST && pend.cmd == CMD_ARR_WRITE)
         begin
            pend.data <= nextByte;
            reqTog    <= ~reqTog;
         end
      end
   end

   // ==========================================================
   // link side: status output

   // status crosses bit by bit; only a twice-seen value is used
   sec_sync #(.W(8)) u_stat_sync
   (
      .clock (sck),
      .d     (statView),
      .q     (statSync)
   );

   // a torn sample never reaches the shifter
   always_ff @(posedge sck)
   begin
      statPrev <= statSync;
      if (statSync == statPrev)
         statStable <= statSync;
   end

   // read mode and byte reload every eighth bit
   always_ff @(posedge sck or posedge csN)
   begin
      if (csN)
      begin
         readMode <= 1'b0;
         outCnt   <= '0;
         outByte  <= '0;
      end
      else if (holdN)
      begin
         if (bitCnt == BIT_OP_LAST && opCmd == CMD_STAT_READ)
         begin
            readMode <= 1'b1;
            outCnt   <= '0;
            outByte  <= statStable;
         end
         else if (readMode)
         begin
            outCnt <= outCnt + 1'b1;
            if (outCnt == 3'h7)
               outByte <= statStable;
         end
      end
   end

   always_ff @(negedge sck or posedge csN)
   begin
      if (csN)
         so <= 1'b0;
      else if (holdN && readMode)
         so <= outByte[~outCnt];
   end

   // ==========================================================
   // core side: pin and link synchronisers

   sec_sync #(.W(5)) u_pin_sync
   (
      .clock (clock),
      .d     ({csN, holdN, wpN, readMode, reqTog}),
      .q     (pinS)
   );

   // registered copy of reset drives the link side reset
   always_ff @(posedge clock)
   begin
      linkRst <= rst;
      csPrev  <= rst ? 1'b1 : pinS.csN;
      lastTog <= pinS.reqTog;
   end

   assign csRise = pinS.csN && !csPrev;
   assign togNew = pinS.reqTog != lastTog;
   assign exec   = csRise && (capValid || togNew);
   assign req    = togNew ? pend : cap;

   // the request is stable before its toggle arrives
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cap      <= '0;
         capValid <= 1'b0;
      end
      else if (csRise)
         capValid <= 1'b0;
      else if (togNew)
      begin
         cap      <= pend;
         capValid <= 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         soEnN <= 1'b1;
      else
         soEnN <= !(!pinS.csN && pinS.holdN && pinS.readMode);
   end

   // ==========================================================
   // core side: protection and write cycle start

   assign hwProt = hwArm && !pinS.wpN;

   always_comb
   begin
      unique case (protLevel)
         PROT_NONE:    arrProt = 1'b0;
         PROT_QUARTER: arrProt = req.addr[9:0] >= PROT_QUARTER_LOW;
         PROT_HALF:    arrProt = req.addr[9:0] >= PROT_HALF_LOW;
         default:      arrProt = 1'b1;
      endcase
   end

   assign startWc = exec && !busy && writeLatch &&
                    ((req.cmd == CMD_STAT_WRITE && !hwProt) ||
                     (req.cmd == CMD_ARR_WRITE && !arrProt));

   sec_wc_timer #(.CYCLES(WRITE_CYCLES)) u_wc_timer
   (
      .clock (clock),
      .rst   (rst),
      .start (startWc),
      .done  (wcDone)
   );

   // busy flag and the held write request
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         busy   <= 1'b0;
         wcKind <= CMD_NONE;
         wcData <= '0;
      end
      else if (startWc)
      begin
         busy   <= 1'b1;
         wcKind <= req.cmd;
         wcData <= req.data;
      end
      else if (wcDone)
         busy <= 1'b0;
   end

   // hand-off to the array write engine
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         arrayWriteGo   <= 1'b0;
         arrayWriteAddr <= '0;
         arrayWriteData <= '0;
      end
      else
      begin
         arrayWriteGo <= startWc && req.cmd == CMD_ARR_WRITE;
         if (startWc && req.cmd == CMD_ARR_WRITE)
         begin
            arrayWriteAddr <= req.addr[9:0];
            arrayWriteData <= req.data;
         end
      end
   end

   // ==========================================================
   // core side: status register

   // write latch; cleared after a finished write cycle
   always_ff @(posedge clock)
   begin
      if (rst)
         writeLatch <= 1'b0;
      else if (wcDone)
         writeLatch <= 1'b0;
      else if (exec && !busy)
      begin
         if (req.cmd == CMD_SET_LATCH)
            writeLatch <= 1'b1;
         else if (req.cmd == CMD_CLR_LATCH)
            writeLatch <= 1'b0;
      end
   end

   // reset stands in for the shipped state; no real retention here
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         protLevel <= PROT_LEVEL_SHIP;
         hwArm     <= ARM_SHIP;
      end
      else if (wcDone && wcKind == CMD_STAT_WRITE)
      begin
         protLevel <= wcData[3:2];
         if (wcData[7] || pinS.wpN)
            hwArm <= wcData[7];
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         statView <= '0;
      else if (busy || startWc)
         statView <= STAT_BUSY_VIEW;
      else
      begin
         statView.hw_protect_arm <= hwArm;
         statView.spare          <= '0;
         statView.protect_level  <= protLevel;
         statView.writeLatch     <= writeLatch;
         statView.busy           <= 1'b0;
      end
   end

endmodule // sec_eeprom_front

// ---- testbench/sec_eeprom_front_properties.sv ----
`timescale 1ns/100ps

// ==========================================================
// port properties of the eeprom front end
module sec_eeprom_front_properties
   import sec_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = WC_CYCLES
)
(
   input wire logic       clock,          // core clock
   input wire logic       rst,            // sync reset
   input wire logic       sck,            // link clock
   input wire logic       csN,            // select, low
   input wire logic       si,             // data in
   input wire logic       holdN,          // pause, low
   input wire logic       wpN,            // protect pin
   input wire logic       so,             // data out
   input wire logic       soEnN,          // out enable, low
   input wire logic       busy,           // write cycle
   input wire logic       arrayWriteGo,   // write start
   input wire logic [9:0] arrayWriteAddr, // write address
   input wire logic [7:0] arrayWriteData  // write byte
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   int unsigned busyLen;

   // busy run length; restarts whenever idle
   always_ff @(posedge clock)
   begin
      if (rst || !busy)
         busyLen <= 0;
      else
         busyLen <= busyLen + 1;
   end

   sequence pausedLong;
      !holdN [*6];
   endsequence
   sequence frameOff;
      csN [*6];
   endsequence
   sequence goStep;
      arrayWriteGo ##1 !arrayWriteGo;
   endsequence

   AST_PAUSE_RELEASE:
      assert property (pausedLong |-> soEnN)
      else $error("so still driven while paused");
   AST_IDLE_RELEASE:
      assert property (frameOff |-> soEnN)
      else $error("so still driven after frame end");
   AST_IDLE_QUIET:
      assert property (csN |-> !so)
      else $error("so not low while deselected");
   AST_GO_ONE:
      assert property (arrayWriteGo |-> goStep)
      else $error("write start longer than one cycle");
   AST_GO_BUSY:
      assert property (arrayWriteGo |-> ##[0:1] busy)
      else $error("write start without busy");
   AST_GO_READY:
      assert property (arrayWriteGo |-> !$past(busy))
      else $error("write started while busy");
   AST_GO_FRAME_END:
      assert property (arrayWriteGo |-> csN)
      else $error("write started inside a frame");
   AST_BUSY_START:
      assert property ($rose(busy) |-> csN && $past(csN))
      else $error("busy rose inside a frame");
   AST_WRITE_LEN:
      assert property ($fell(busy) |-> busyLen >= WRITE_CYCLES
                       && busyLen <= WRITE_CYCLES + 2)
      else $error("write cycle length wrong");
   AST_RESET_STATE:
      assert property ($fell(rst) |-> !busy && !arrayWriteGo && soEnN)
      else $error("outputs not idle after reset");
endmodule // sec_eeprom_front_properties

bind sec_eeprom_front sec_eeprom_front_properties
   #(.WRITE_CYCLES(WRITE_CYCLES)) props
   (.clock(clock), .rst(rst), .sck(sck), .csN(csN), .si(si),
    .holdN(holdN), .wpN(wpN), .so(so), .soEnN(soEnN), .busy(busy),
    .arrayWriteGo(arrayWriteGo), .arrayWriteAddr(arrayWriteAddr),
    .arrayWriteData(arrayWriteData));

// ---- testbench/sec_spi_master.sv ----
`timescale 1ns/100ps

// ==========================================================
// mode 0 master; clock stands still between frames
module sec_spi_master
(
   output logic      sck,   // serial clock, 80 ns
   output logic      csN,   // chip select, low
   output logic      si,    // data to device
   output logic      holdN, // pause, low
   input  wire logic so,    // data from device
   input  wire logic soEnN  // device drives so when low
);
   // select starts low and rises at 1 ns, so the frame logic sees a real
   // select edge; a value set at time zero could be missed
   initial
   begin
      sck = 1'b0;
      csN = 1'b0;
      si = 1'b0;
      holdN = 1'b1;
      #1 csN = 1'b1;
   end

   // sends the n low bits of tx, MSB first; a pause adds three clocks of toggled data
   task automatic frame(input logic [31:0] tx, input int n,
                        input int holdAt, output logic [31:0] rx,
                        output logic offSeen);
      rx = '0;
      offSeen = 1'b1;
      csN = 1'b0;
      #100;
      for (int i = 0; i < n; i++)
      begin
         si = tx[n-1-i];
         if (i == holdAt)
         begin
            // pause moves with clock low, never at an edge
            #20 holdN = 1'b0;
            repeat (3)
            begin
               #20 sck = 1'b1;
               si = ~si;
               #40 sck = 1'b0;
               #20;
            end
            offSeen = soEnN;
            si = tx[n-1-i];
            holdN = 1'b1;
            #20;
         end
         #40 sck = 1'b1;
         rx = {rx[30:0], so};
         #40 sck = 1'b0;
      end
      #20 csN = 1'b1;
      si = ~si; // released line shows inverse, not last bit
      #400;
   endtask
endmodule // sec_spi_master

// ---- testbench/sec_eeprom_front_bench.sv ----
`timescale 1ns/100ps

// ==========================================================
// self-checking bench, short write cycle
module sec_eeprom_front_bench;
   import sec_pkg::*;
   localparam int unsigned WCYC = 1000;
   logic       clock, rst, wpN, sck, csN, si, holdN;
   logic       so, soEnN, busy, arrayWriteGo, off;
   logic [9:0] arrayWriteAddr, goAddr;
   logic [7:0] arrayWriteData, goData;
   logic [31:0] rx;
   logic [1:0] lv;
   logic [9:0] okA [4] = '{10'h3FF, 10'h2FF, 10'h1FF, 10'h000};
   logic [9:0] badA [4] = '{10'h000, 10'h300, 10'h200, 10'h000};
   int         miscompares, n_compared, goCount, cycles, g;

   sec_eeprom_front #(.WRITE_CYCLES(WCYC)) dut
   (.clock(clock), .rst(rst), .sck(sck), .csN(csN), .si(si),
    .holdN(holdN), .wpN(wpN), .so(so), .soEnN(soEnN), .busy(busy),
    .arrayWriteGo(arrayWriteGo), .arrayWriteAddr(arrayWriteAddr),
    .arrayWriteData(arrayWriteData));

   sec_spi_master m
   (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so),
    .soEnN(soEnN));

   always #4 clock = ~clock;

   // write start monitor and hang guard; falling edge keeps it
   // clear of the edge that launches the pulse
   always @(negedge clock)
   begin
      cycles++;
      if (arrayWriteGo === 1'b1)
      begin
         goCount++;
         goAddr = arrayWriteAddr;
         goData = arrayWriteData;
      end
      if (cycles == 60000)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: timeout", $time);
         conclude();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      m.frame({24'h0, op}, 8, -1, rx, off);
   endtask
   task automatic sw(input logic [7:0] d);
      m.frame({16'h0, 8'h01, d}, 16, -1, rx, off);
   endtask
   task automatic aw(input logic [9:0] a, input logic [7:0] d);
      m.frame({8'h02, 6'h0, a, d}, 32, -1, rx, off);
   endtask
   task automatic st(input logic [7:0] exp);
      m.frame(32'h0500_0000, 32, -1, rx, off);
      check(rx[7:0], exp);
   endtask
   task automatic waitIdle();
      for (int k = 0; k < 2000 && busy !== 1'b0; k++)
         @(negedge clock);
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      wpN = 1'b1;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      repeat (6) @(negedge clock);
      st(8'h00);
      cmd(8'h06);
      st(8'h02);
      cmd(8'h0C);
      st(8'h00);
      cmd(8'h0E);
      st(8'h02);
      cmd(8'h04);
      sw(8'h8C);
      st(8'h00);
      $display("latch tests done");
      cmd(8'h06);
      sw(8'hFC);
      check(busy, 1);
      st(8'hFF);
      cmd(8'h06);
      waitIdle();
      st(8'h8C);
      @(negedge clock) wpN = 1'b0;
      cmd(8'h06);
      sw(8'h00);
      check(busy, 0);
      st(8'h8E);
      @(negedge clock) wpN = 1'b1;
      sw(8'h00);
      waitIdle();
      st(8'h00);
      $display("status write tests done");
      for (int l = 0; l < 4; l++)
      begin
         lv = 2'(l);
         cmd(8'h06);
         sw({4'h0, lv, 2'b00});
         waitIdle();
         st({4'h0, lv, 2'b00});
         g = goCount;
         if (l < 3)
         begin
            cmd(8'h06);
            aw(okA[l], 8'hA5);
            waitIdle();
            check(goCount - g, 1);
            check({goAddr, goData}, {okA[l], 8'hA5});
         end
         g = goCount;
         if (l > 0)
         begin
            cmd(8'h06);
            aw(badA[l], 8'h5A);
            check(goCount - g, 0);
            check(busy, 0);
         end
      end
      g = goCount;
      m.frame(32'h0300_0000, 32, -1, rx, off);
      check(rx, 32'h0);
      check(goCount - g, 0);
      $display("protect level tests done");
      m.frame(32'h0500_0000, 32, 12, rx, off);
      check(rx[15:0], 16'h0E0E);
      check(off, 1);
      $display("pause tests done");
      conclude();
   end
endmodule // sec_eeprom_front_bench
